// ---- rtl/link_page_bank.sv ----
/*
  Paged per-link register bank with embedded-line type tagging.
  Assumes register requests and packet requests are synchronous to
  CORE_CLK and one request of each kind at most per cycle.
*/
// Function
// R1 - Accesses to 0x4D-0x7F and 0xD0-0xDF go to the link blocks chosen by page select.
// R2 - Page select bits 5:4 pick which of four links answers reads.
// R3 - Page select bits 3:0 enable writes per link, broadcasting to all enabled links.
// R4 - For local I2C access the read select defaults to link 0.
// R5 - For control channel access the read select defaults to the arrival link.
// R6 - For control channel access the arrival link's write enable defaults to 1.
// R7 - Page select bits 7:6 read 0 locally and the arrival link over the control channel.
// R8 - Each access source keeps its own page select copy.
// R9 - Link status one bits 7:6 report the currently read-selected link.
// R10 - With embedded enable 0 every long packet keeps its pixel type.
// R11 - With enable 1, 2 or 3 the first that many long packets of a frame get the embedded type.
// R12 - The embedded type is the six-bit code in bits 5:0, reset 0x12.
// R13 - Embedded tagging has no effect on CSI-2 formatted input.
// R14 - The embedded type register at 0x4B is paged per link through 0x4C.
// R15 - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module link_page_bank #(
  parameter logic [5:0] TWELVE_BIT_PIXEL_TYPE = 6'h2C,
  parameter logic [5:0] TEN_BIT_PIXEL_TYPE    = 6'h2B
) (
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST_B,
  input  wire link_page_pkg::reg_req_t REG_REQ,
  output logic                       RD_VALID,
  output logic [7:0]                 RD_DATA,
  input  wire link_page_pkg::pkt_req_t PKT_REQ,
  output logic                       DT_VALID,
  output logic [5:0]                 DT_CODE
);

  localparam int NL = link_page_pkg::NUM_LINKS;

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_meta_q, rst_b_q;

  // Two-stage release so all state leaves reset on one edge
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_b_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_b_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  function automatic logic is_paged(input logic [7:0] a);
    return (a >= link_page_pkg::PAGED_LO_A && a <= link_page_pkg::PAGED_HI_A) ||
           (a >= link_page_pkg::PAGED_LO_B && a <= link_page_pkg::PAGED_HI_B) ||
           (a == link_page_pkg::EMBED_CFG_OFS);
  endfunction

  // Page select value after reset for each source
  function automatic logic [7:0] sel_default(input int s);
    logic [7:0] v;
    v = link_page_pkg::PAGE_SEL_RST;
    if (s != 0) begin
      v[link_page_pkg::RD_HI:link_page_pkg::RD_LO] = 2'(s - 1); // R5
      v[s - 1] = 1'b1;                                          // R6
    end
    return v;
  endfunction

  logic [2:0] src;
  assign src = REG_REQ.remote ? {1'b0, REG_REQ.physical_link_index} + 3'h1
                              : link_page_pkg::SRC_LOCAL;

  // ------------------------------------------------------------------
  // Page select copies, one per access source
  // ------------------------------------------------------------------
  logic [5:0] sel_q [link_page_pkg::NUM_SRC];
  logic       sel_wr;
  assign sel_wr = REG_REQ.valid && REG_REQ.write &&
                  REG_REQ.addr == link_page_pkg::PAGE_SEL_OFS;

  // Only the requesting source's copy moves; bits 7:6 are not stored
  always_ff @(posedge CORE_CLK or negedge rst_b_q) begin
    if (!rst_b_q) begin
      for (int s = 0; s < link_page_pkg::NUM_SRC; s++) begin
        sel_q[s] <= 6'(sel_default(s));                        // R4 R5 R6
      end
    end else if (sel_wr) begin
      sel_q[src] <= REG_REQ.wdata[link_page_pkg::RD_HI:0];     // R8
    end
  end

  logic [5:0] cur_sel;
  logic [1:0] rd_link;
  logic [3:0] wr_en;
  assign cur_sel = sel_q[src];
  assign rd_link = cur_sel[link_page_pkg::RD_HI:link_page_pkg::RD_LO]; // R2
  assign wr_en   = cur_sel[link_page_pkg::WR_HI:0];                    // R3

  // ------------------------------------------------------------------
  // Per-link paged storage
  // ------------------------------------------------------------------
  // Generic paged bytes stand in for the link registers outside scope
  logic [7:0] embed_q [NL];
  logic [7:0] paged_q [NL][16];
  logic       paged_wr;
  assign paged_wr = REG_REQ.valid && REG_REQ.write && is_paged(REG_REQ.addr);

  // Broadcast write: every enabled link updates together
  always_ff @(posedge CORE_CLK or negedge rst_b_q) begin
    if (!rst_b_q) begin
      for (int l = 0; l < NL; l++) begin
        embed_q[l] <= link_page_pkg::EMBED_CFG_RST;            // R12
        for (int i = 0; i < 16; i++) begin
          paged_q[l][i] <= 8'h00;
        end
      end
    end else if (paged_wr) begin
      for (int l = 0; l < NL; l++) begin
        if (wr_en[l]) begin                                    // R1 R3
          if (REG_REQ.addr == link_page_pkg::EMBED_CFG_OFS) begin
            embed_q[l] <= REG_REQ.wdata;                       // R14
          end else if (REG_REQ.addr[7:4] == 4'hD) begin
            paged_q[l][REG_REQ.addr[3:0]] <= REG_REQ.wdata;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;                                              // R15
    if (REG_REQ.addr == link_page_pkg::PAGE_SEL_OFS) begin
      rd_d = {REG_REQ.remote ? REG_REQ.physical_link_index : 2'h0, cur_sel}; // R7
    end else if (REG_REQ.addr == link_page_pkg::EMBED_CFG_OFS) begin
      rd_d = embed_q[rd_link];                                 // R14 R2
    end else if (REG_REQ.addr == link_page_pkg::LINK_STS1_OFS) begin
      rd_d = {rd_link, 6'h00};                                 // R9
    end else if (is_paged(REG_REQ.addr) && REG_REQ.addr[7:4] == 4'hD) begin
      rd_d = paged_q[rd_link][REG_REQ.addr[3:0]];              // R1
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge CORE_CLK or negedge rst_b_q) begin
    if (!rst_b_q) begin
      RD_VALID <= 1'b0;
      RD_DATA  <= 8'h00;
    end else begin
      RD_VALID <= REG_REQ.valid && !REG_REQ.write;
      RD_DATA  <= (REG_REQ.valid && !REG_REQ.write) ? rd_d : RD_DATA;
    end
  end

  // ------------------------------------------------------------------
  // Embedded line type tagging
  // ------------------------------------------------------------------
  logic [1:0] pkt_cnt_q [NL];
  logic [7:0] cfg;
  logic [1:0] n_emb;
  logic [1:0] cnt_now;
  assign cfg     = embed_q[PKT_REQ.link];
  assign n_emb   = cfg[link_page_pkg::EN_HI:link_page_pkg::EN_LO];
  assign cnt_now = PKT_REQ.frame_start ? 2'h0 : pkt_cnt_q[PKT_REQ.link];

  // Count long packets per frame; saturates at three
  always_ff @(posedge CORE_CLK or negedge rst_b_q) begin
    if (!rst_b_q) begin
      for (int l = 0; l < NL; l++) begin
        pkt_cnt_q[l] <= 2'h0;
      end
    end else if (PKT_REQ.valid) begin
      pkt_cnt_q[PKT_REQ.link] <= (cnt_now == 2'h3) ? 2'h3 : cnt_now + 2'h1;
    end
  end

  // Type chosen per packet
  always_ff @(posedge CORE_CLK or negedge rst_b_q) begin
    if (!rst_b_q) begin
      DT_VALID <= 1'b0;
      DT_CODE  <= 6'h00;
    end else begin
      DT_VALID <= PKT_REQ.valid;
      if (PKT_REQ.valid) begin
        if (!PKT_REQ.csi_input && cnt_now < n_emb) begin       // R10 R11 R13
          DT_CODE <= cfg[link_page_pkg::CODE_HI:0];            // R12
        end else begin
          DT_CODE <= PKT_REQ.twelve_bit ? TWELVE_BIT_PIXEL_TYPE : TEN_BIT_PIXEL_TYPE;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_local_sel_read;
    REG_REQ.valid && !REG_REQ.write && !REG_REQ.remote &&
    REG_REQ.addr == link_page_pkg::PAGE_SEL_OFS;
  endsequence

  AST_LOCAL_TOP_ZERO: assert property (@(posedge CORE_CLK) disable iff (!rst_b_q) // R7
    s_local_sel_read |=> RD_VALID && RD_DATA[7:6] == 2'h0)
    else $error("Local page select read shows nonzero link bits");

  AST_STS1_LINK: assert property (@(posedge CORE_CLK) disable iff (!rst_b_q) // R9
    (REG_REQ.valid && !REG_REQ.write && REG_REQ.addr == link_page_pkg::LINK_STS1_OFS)
    |=> RD_DATA[7:6] == $past(rd_link) && RD_DATA[5:0] == 6'h00)
    else $error("Status one link field wrong");

  AST_PIXEL_WHEN_OFF: assert property (@(posedge CORE_CLK) disable iff (!rst_b_q) // R10
    (PKT_REQ.valid && n_emb == 2'h0 && !PKT_REQ.twelve_bit) |=> DT_CODE == TEN_BIT_PIXEL_TYPE)
    else $error("Pixel type not kept with tagging off");

  AST_CSI_NO_TAG: assert property (@(posedge CORE_CLK) disable iff (!rst_b_q) // R13
    (PKT_REQ.valid && PKT_REQ.csi_input && PKT_REQ.twelve_bit) |=> DT_CODE == TWELVE_BIT_PIXEL_TYPE)
    else $error("Embedded type applied to CSI-2 input");

  AST_FIRST_TAGGED: assert property (@(posedge CORE_CLK) disable iff (!rst_b_q) // R11
    (PKT_REQ.valid && PKT_REQ.frame_start && !PKT_REQ.csi_input && n_emb != 2'h0)
    |=> DT_CODE == $past(cfg[5:0]))
    else $error("First packet of frame not tagged");

  AST_WR_MASKED: assert property (@(posedge CORE_CLK) disable iff (!rst_b_q) // R3
    (paged_wr && REG_REQ.addr == link_page_pkg::EMBED_CFG_OFS && !wr_en[0])
    |=> $stable(embed_q[0]))
    else $error("Disabled link took a write");

  AST_WR_TAKEN: assert property (@(posedge CORE_CLK) disable iff (!rst_b_q) // R3
    (paged_wr && REG_REQ.addr == link_page_pkg::EMBED_CFG_OFS && wr_en[3])
    |=> embed_q[3] == $past(REG_REQ.wdata))
    else $error("Enabled link missed a write");

  AST_SEL_RD: assert property (@(posedge CORE_CLK) disable iff (!rst_b_q) // R2
    (REG_REQ.valid && !REG_REQ.write && REG_REQ.addr == link_page_pkg::EMBED_CFG_OFS)
    |=> RD_DATA == $past(embed_q[rd_link]))
    else $error("Read not from selected link");

  AST_UNMAPPED_ZERO: assert property (@(posedge CORE_CLK) disable iff (!rst_b_q) // R15
    (REG_REQ.valid && !REG_REQ.write && REG_REQ.addr == 8'h00) |=> RD_DATA == 8'h00)
    else $error("Unmapped read not zero");

endmodule

`default_nettype wire

// ---- rtl/link_page_pkg.sv ----
/*
  Package for the paged per-link register bank: offsets, reset values,
  field positions and the carrier structs shared by the design.
  Assumes an 8-bit register access path already decoded from I2C or the
  bidirectional control channel by upstream logic.
*/
package link_page_pkg;

  // ------------------------------------------------------------------
  // Register offsets and paged ranges
  // ------------------------------------------------------------------
  localparam logic [7:0] EMBED_CFG_OFS   = 8'h4B;
  localparam logic [7:0] PAGE_SEL_OFS    = 8'h4C;
  localparam logic [7:0] LINK_STS1_OFS   = 8'h4D;
  localparam logic [7:0] PAGED_LO_A      = 8'h4D;
  localparam logic [7:0] PAGED_HI_A      = 8'h7F;
  localparam logic [7:0] PAGED_LO_B      = 8'hD0;
  localparam logic [7:0] PAGED_HI_B      = 8'hDF;

  // ------------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] EMBED_CFG_RST   = 8'h12;
  localparam logic [7:0] PAGE_SEL_RST    = 8'h00;
  localparam int         EN_HI           = 7;
  localparam int         EN_LO           = 6;
  localparam int         CODE_HI         = 5;
  localparam int         RD_HI           = 5;
  localparam int         RD_LO           = 4;
  localparam int         WR_HI           = 3;

  // Access sources: local I2C plus one control channel per link
  localparam int         NUM_LINKS       = 4;
  localparam int         NUM_SRC         = 5;
  localparam logic [2:0] SRC_LOCAL       = 3'h0;

  // One register access as seen by the bank
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       remote;       // Arrived over the bidirectional control channel
    logic [1:0] physical_link_index;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Per-packet tagging request from a link datapath
  typedef struct packed {
    logic       valid;
    logic       frame_start;
    logic [1:0] link;
    logic       csi_input;    // Link receiver takes CSI-2 formatted data
    logic       twelve_bit;   // Raw stream is 12-bit rather than 10-bit
  } pkt_req_t;

endpackage

// ---- tb/reg_host.sv ----
/*
  Register host model: issues single-byte accesses, local or over
  the bidirectional control channel, one cycle each.
  Assumes the bank takes a request at the rising edge with valid high.
*/
`timescale 1ns/1ps
`default_nettype none
module reg_host (
  input  wire logic                     CORE_CLK,
  output link_page_pkg::reg_req_t       REG_REQ,
  input  wire logic                     RD_VALID,
  input  wire logic [7:0]               RD_DATA
);
  logic       rv_q;
  logic [7:0] rd_q;
  initial REG_REQ = '0;
  // Idle fields show the inverse so a stale value is never mistaken for live
  task automatic access(input logic wr, input logic rem, input logic [1:0] lnk,
                        input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_REQ <= '{1'b1, wr, rem, lnk, a, d};
    @(posedge CORE_CLK);
    REG_REQ <= '{1'b0, ~wr, ~rem, ~lnk, ~a, ~d};
    #1;
    rv_q = RD_VALID;
    rd_q = RD_DATA;
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the paged link register bank.
  Assumes reg_host drives the register path; packets come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                     CORE_CLK;
  logic                     RST_B;
  link_page_pkg::reg_req_t  REG_REQ;
  link_page_pkg::pkt_req_t  PKT_REQ;
  logic                     RD_VALID;
  logic                     DT_VALID;
  logic [7:0]               RD_DATA;
  logic [5:0]               DT_CODE;
  int                       n_fail;
  int                       samples_checked;

  initial CORE_CLK = 1'b0;
  always #2 CORE_CLK = ~CORE_CLK;

  link_page_bank link_page_bank_inst (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_REQ(REG_REQ),
    .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .PKT_REQ(PKT_REQ), .DT_VALID(DT_VALID),
    .DT_CODE(DT_CODE));
  reg_host reg_host_inst (.CORE_CLK(CORE_CLK), .REG_REQ(REG_REQ), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA));

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic rem, input logic [1:0] lnk, input logic [7:0] a,
                    input logic [7:0] d);
    reg_host_inst.access(1'b1, rem, lnk, a, d);
  endtask
  task automatic rd(input logic rem, input logic [1:0] lnk, input logic [7:0] a,
                    input logic [7:0] exp);
    reg_host_inst.access(1'b0, rem, lnk, a, 8'h00);
    check({7'h00, reg_host_inst.rv_q}, 8'h01, "read answer");
    check(reg_host_inst.rd_q, exp, "read data");
  endtask
  // One long packet; a CSI packet must merely avoid the embedded code
  task automatic pkt(input logic [1:0] lnk, input logic fs, input logic csi,
                     input logic tw, input logic [5:0] exp);
    @(posedge CORE_CLK);
    PKT_REQ <= '{1'b1, fs, lnk, csi, tw};
    @(posedge CORE_CLK);
    PKT_REQ <= '{1'b0, ~fs, ~lnk, ~csi, ~tw};
    #1;
    check({7'h00, DT_VALID}, 8'h01, "type answer");
    if (csi) check({7'h00, DT_CODE === exp}, 8'h00, "csi tagged");
    else check({2'h0, DT_CODE}, {2'h0, exp}, "type code");
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_defaults;
    rd(1'b0, 2'h0, 8'h4C, 8'h00);
    rd(1'b1, 2'h2, 8'h4C, 8'hA4);
    rd(1'b0, 2'h0, 8'h4B, 8'h12);
    rd(1'b0, 2'h0, 8'h4D, 8'h00);
    rd(1'b0, 2'h0, 8'h00, 8'h00);
    rd(1'b0, 2'h0, 8'h4E, 8'h00);
  endtask
  // Broadcast to links 0 and 2, then read every page back
  task automatic t_broadcast;
    wr(1'b0, 2'h0, 8'h4C, 8'h05);
    wr(1'b0, 2'h0, 8'hD0, 8'h5A);
    wr(1'b0, 2'h0, 8'hDF, 8'hC3);
    for (int k = 0; k < 4; k++) begin
      wr(1'b0, 2'h0, 8'h4C, {2'h0, 2'(k), 4'h0});
      rd(1'b0, 2'h0, 8'hD0, (k == 0 || k == 2) ? 8'h5A : 8'h00);
      rd(1'b0, 2'h0, 8'hDF, (k == 0 || k == 2) ? 8'hC3 : 8'h00);
      rd(1'b0, 2'h0, 8'h4D, {2'(k), 6'h00});
    end
    wr(1'b0, 2'h0, 8'h4C, 8'hFF);
    rd(1'b0, 2'h0, 8'h4C, 8'h3F);
  endtask
  // Page state of one source must not leak into another
  task automatic t_sources;
    rd(1'b1, 2'h1, 8'h4C, 8'h52);
    wr(1'b1, 2'h1, 8'h4C, 8'h38);
    rd(1'b0, 2'h0, 8'h4C, 8'h3F);
    rd(1'b1, 2'h1, 8'h4C, 8'h78);
    rd(1'b1, 2'h3, 8'h4C, 8'hF8);
  endtask
  // Config write with only link 3 enabled must leave link 0 alone
  task automatic t_mask;
    wr(1'b0, 2'h0, 8'h4C, 8'h08);
    wr(1'b0, 2'h0, 8'h4B, 8'h47);
    rd(1'b0, 2'h0, 8'h4B, 8'h12);
    wr(1'b0, 2'h0, 8'h4C, 8'h30);
    rd(1'b0, 2'h0, 8'h4B, 8'h47);
    wr(1'b1, 2'h3, 8'h4B, 8'h8C);
    rd(1'b1, 2'h3, 8'h4B, 8'h8C);
    rd(1'b0, 2'h0, 8'h4B, 8'h8C);
  endtask
  // Every enable count on link 0; link 1 keeps its reset config
  task automatic t_embed;
    wr(1'b0, 2'h0, 8'h4C, 8'h01);
    for (int en = 0; en < 4; en++) begin
      wr(1'b0, 2'h0, 8'h4B, {2'(en), 6'h15});
      rd(1'b0, 2'h0, 8'h4B, {2'(en), 6'h15});
      for (int p = 0; p < 4; p++) begin
        pkt(2'h0, p == 0, 1'b0, 1'b1, (p < en) ? 6'h15 : 6'h2C);
      end
      pkt(2'h1, 1'b1, 1'b0, 1'b0, 6'h2B);
    end
    pkt(2'h0, 1'b1, 1'b1, 1'b1, 6'h15);
  endtask

  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #20000;
    n_fail++;
    stop_test();
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    RST_B = 1'b0;
    PKT_REQ = '0;
    repeat (8) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    t_defaults();
    t_broadcast();
    t_sources();
    t_mask();
    t_embed();
    stop_test();
  end
endmodule
`default_nettype wire
